//--- hdl/i2c_margin_pkg.sv
// Shared constants for the margining / supervisor command link.
// Assumes a single 200 MHz core clock on both ends.
package i2c_margin_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;
  localparam int unsigned I2C_HZ        = 400_000;
  localparam int unsigned QUARTER_CYC   = CLK_HZ / (4 * I2C_HZ);
  // Supervisor timer and current limit times, in ms
  localparam int unsigned WD_BASE_MS    = 20;
  localparam int unsigned WD_CODE_MAX   = 3;
  localparam int unsigned ILIM_TRIP_MS  = 10;
  localparam int unsigned ILIM_RETRY_MS = 100;
  // Slave address and command byte layout
  localparam logic [4:0] ADDR_FIXED     = 5'h1D;
  localparam logic [2:0] OP_MARGIN      = 3'h1;
  localparam logic [2:0] OP_WATCHDOG    = 3'h3;
  localparam logic [4:0] VAL_NULL       = 5'h00;
  localparam logic [7:0] GUARD_MARGIN   = {OP_MARGIN, VAL_NULL};
  localparam logic [7:0] GUARD_WD       = {OP_WATCHDOG, VAL_NULL};
  localparam int         SEL_BIT        = 4;
  localparam int         WIN_BIT        = 2;
  localparam logic [1:0] WD_PROG_TAG    = 2'h1;
  localparam logic [3:0] MARGIN_BAD     = 4'hF;
  // Controller register map (byte addresses)
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_DATA       = 8'h04;
  localparam logic [7:0] REG_STATUS     = 8'h08;
  localparam logic [7:0] REG_INT_STATUS = 8'h0C;
  localparam logic [7:0] REG_INT_MASK   = 8'h10;
  localparam logic [7:0] REG_DIV        = 8'h14;
  // Field positions
  localparam int         CTRL_GO        = 0;
  localparam int         CTRL_KIND_LSB  = 1;
  localparam int         CTRL_SEL_LSB   = 3;
  localparam int         DATA_V1_LSB    = 8;
  localparam int         INT_DONE       = 0;
  localparam int         INT_NACK       = 1;
  localparam logic [15:0] DIV_RESET     = 16'(QUARTER_CYC);
  // Frame kinds the controller can send
  typedef enum logic [1:0] {
    KIND_MARGIN_ONE,
    KIND_MARGIN_BOTH,
    KIND_WD_SERVICE,
    KIND_WD_OFF
  } kind_t;
endpackage

//--- hdl/i2c_link_if.sv
// Two-wire link between controller and device.
// Open-drain: a party pulls low while its enable is high and output low.
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic m_scl_out, m_scl_oe, m_sda_out, m_sda_oe;  // Controller pins
  logic d_scl_out, d_scl_oe, d_sda_out, d_sda_oe;  // Device pins
  logic scl, sda;                                  // Resolved levels
  // Wired-AND with pull-ups
  assign scl = !((m_scl_oe && !m_scl_out) || (d_scl_oe && !d_scl_out));
  assign sda = !((m_sda_oe && !m_sda_out) || (d_sda_oe && !d_sda_out));
  modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
  modport device (output d_scl_out, d_scl_oe, d_sda_out, d_sda_oe, input scl, sda);
endinterface
`default_nettype wire

//--- hdl/i2c_margin_watchdog_cmd.sv
// Device end: write-only command interpreter behind a two-wire slave,
// margin code outputs, supervisor timer and linear regulator limit timer.
// Assumes link levels synchronous to core_clk and a sync active-high reset.
//
// Function
// RQ1 - Operation byte must follow its matching guard
// RQ2 - Guard is op code plus zero value
// RQ3 - Both margins: one guard, two bytes
// RQ4 - Master services supervisor timer periodically
// RQ5 - Valid programming byte after guard starts timer
// RQ6 - In-window refresh clears timer, applies timing
// RQ7 - Two watchdog guards in row disable timer
// RQ8 - Later valid programming byte re-enables timer
// RQ9 - Only STOP ends transfer; return idle
// RQ10 - Master always addresses with write direction
// RQ11 - Code 001 0 0101: linear +5 percent
// RQ12 - Code 001 1 1100: switcher -5 percent
// RQ13 - Overcurrent 10 ms trips, 100 ms retry
// RQ14 - Byte is 3-bit op, 5-bit value
// RQ15 - Two address LSBs follow strap inputs
// RQ16 - Unguarded operation bytes change nothing
`timescale 1ns/1ps
`default_nettype none
module i2c_margin_watchdog_cmd #(
  parameter int unsigned MS_CYCLES = i2c_margin_pkg::MS_CYCLES  // Core cycles per ms
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  i2c_link_if.device      link,
  input  wire logic       oscillator_mode_strap,   // Address bit 1 strap
  input  wire logic       addr_strap,              // Address bit 0 strap
  input  wire logic       ldo_overcurrent,         // Sense above threshold
  output logic [3:0]      ldo_margin_code,         // Linear margin code
  output logic [3:0]      sw_margin_code,          // Switcher margin code
  output logic            supervisor_timer_on,     // Timer running
  output logic            supervisor_timer_window, // Windowed mode
  output logic [1:0]      supervisor_timer_period, // Period code
  output logic            supervisor_timeout,      // One-cycle expiry/fault
  output logic            ldo_enable,              // Regulator allowed on
  output logic            ldo_limit_active         // Limiting current now
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_ACK,
    D_DATA,
    D_IGNORE
  } dst_t;

  typedef struct packed {
    dst_t        st;         // Serial receiver state
    logic        scl_q;      // Previous clock level
    logic        sda_q;      // Previous data level
    logic [3:0]  bitcnt;     // Bits of the current byte
    logic [7:0]  shreg;      // Incoming byte
    logic        sda_oe;     // Pulling data low for acknowledge
    logic [1:0]  a_sel;      // Strapped address bits
    logic        arm_mg;     // Margin guard seen in this transfer
    logic        arm_wd;     // Watchdog guard seen in this transfer
    logic        last_wdg;   // Previous byte was a watchdog guard
    logic [3:0]  ldo_code;   // Linear margin code
    logic [3:0]  sw_code;    // Switcher margin code
    logic        wd_on;      // Supervisor timer running
    logic        wd_win;     // Windowed mode
    logic [1:0]  wd_per;     // Period code
    logic [10:0] wd_ms;      // Elapsed ms
    logic        timeout;    // Expiry or early refresh pulse
    logic [17:0] pre;        // ms prescaler
    logic        tick;       // One-cycle ms tick
    logic        ldo_en;     // Regulator enable
    logic [6:0]  ilim_ms;    // Limit or retry ms count
    logic        ilim_act;   // Limiting now
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;

  // Period in ms: 1280, 320, 80, 20 for codes 0..3
  function automatic logic [10:0] wd_limit(input logic [1:0] per);
    int unsigned ms;
    ms = i2c_margin_pkg::WD_BASE_MS << (2 * (i2c_margin_pkg::WD_CODE_MAX - int'(per)));
    return 11'(ms);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  // All behaviour in one pass; serial decode placed last so a command wins
  // over a timer step that lands in the same cycle.
  always_comb begin
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] b;
    logic       open_win;
    rise     = !s.scl_q && link.scl;
    fall     = s.scl_q && !link.scl;
    start    = s.scl_q && link.scl && s.sda_q && !link.sda;
    stop     = s.scl_q && link.scl && !s.sda_q && link.sda;
    b        = s.shreg;
    open_win = !s.wd_win || (s.wd_ms >= (wd_limit(s.wd_per) >> 1));
    next_s         = s;
    next_s.timeout = 1'b0;
    next_s.scl_q   = link.scl;
    next_s.sda_q   = link.sda;
    // RQ15 strap address bits
    next_s.a_sel   = {oscillator_mode_strap, addr_strap};

    // Millisecond time base shared by both timers
    next_s.tick = 1'b0;
    if (s.pre == 18'(MS_CYCLES - 1)) begin
      next_s.pre  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.pre = s.pre + 18'd1;
    end

    // RQ13 limit and retry timing
    next_s.ilim_act = s.ldo_en && ldo_overcurrent;
    if (s.ldo_en) begin
      if (!ldo_overcurrent) begin
        next_s.ilim_ms = '0;
      end else if (s.tick) begin
        // Trip once the overload has lasted the full limit time
        if (s.ilim_ms == 7'(i2c_margin_pkg::ILIM_TRIP_MS - 1)) begin
          next_s.ldo_en   = 1'b0;
          next_s.ilim_ms  = '0;
        end else begin
          next_s.ilim_ms = s.ilim_ms + 7'd1;
        end
      end
    end else if (s.tick) begin
      // Off period, then try again regardless of load
      if (s.ilim_ms == 7'(i2c_margin_pkg::ILIM_RETRY_MS - 1)) begin
        next_s.ldo_en  = 1'b1;
        next_s.ilim_ms = '0;
      end else begin
        next_s.ilim_ms = s.ilim_ms + 7'd1;
      end
    end

    // Supervisor timer counts while enabled and restarts on expiry
    if (s.wd_on && s.tick) begin
      if (s.wd_ms + 11'd1 >= wd_limit(s.wd_per)) begin
        next_s.wd_ms   = '0;
        next_s.timeout = 1'b1;
      end else begin
        next_s.wd_ms = s.wd_ms + 11'd1;
      end
    end

    // Serial receiver
    unique case (s.st)
      D_IDLE, D_IGNORE: begin
        next_s.sda_oe = 1'b0;
      end
      D_ADDR, D_DATA: begin
        if (rise) begin
          next_s.shreg  = {s.shreg[6:0], link.sda};
          next_s.bitcnt = s.bitcnt + 4'd1;
        end else if (fall && s.bitcnt == 4'd8) begin
          next_s.bitcnt = '0;
          if (s.st == D_ADDR) begin
            // Write direction only; a read request is not acknowledged
            if (b[7:1] == {i2c_margin_pkg::ADDR_FIXED, s.a_sel} && !b[0]) begin
              next_s.sda_oe = 1'b1;
              next_s.st     = D_ACK;
            end else begin
              next_s.st = D_IGNORE;
            end
          end else begin
            // Every byte is acknowledged; only its effect is filtered
            next_s.sda_oe   = 1'b1;
            next_s.st       = D_ACK;
            next_s.last_wdg = 1'b0;
            // RQ14 split op and value
            if (b == i2c_margin_pkg::GUARD_WD) begin
              if (s.last_wdg) begin
                // RQ7 double guard disables
                next_s.wd_on  = 1'b0;
                next_s.wd_ms  = '0;
                next_s.arm_wd = 1'b0;
              end else begin
                // RQ2 watchdog guard arms
                next_s.arm_wd   = 1'b1;
                next_s.arm_mg   = 1'b0;
                next_s.last_wdg = 1'b1;
              end
            end else if (b == i2c_margin_pkg::GUARD_MARGIN && !s.arm_mg) begin
              // RQ2 margin guard arms
              next_s.arm_mg = 1'b1;
              next_s.arm_wd = 1'b0;
            end else if (s.arm_mg && b[7:5] == i2c_margin_pkg::OP_MARGIN &&
                         b[3:0] != i2c_margin_pkg::MARGIN_BAD) begin
              // RQ11 selector low: linear output
              // RQ12 selector high: switcher output
              // Guard stays armed so a second supply byte may follow
              if (b[i2c_margin_pkg::SEL_BIT]) begin
                next_s.sw_code = b[3:0];
              end else begin
                next_s.ldo_code = b[3:0];
              end
            end else if (s.arm_wd && b[7:5] == i2c_margin_pkg::OP_WATCHDOG &&
                         b[4:3] == i2c_margin_pkg::WD_PROG_TAG) begin
              next_s.arm_wd = 1'b0;
              // RQ5 start timer
              // RQ6 clear and retime
              // RQ8 re-enable after off
              // A refresh inside a closed window is a fault, still retimes
              next_s.timeout = s.wd_on && !open_win;
              next_s.wd_on   = 1'b1;
              next_s.wd_win  = b[i2c_margin_pkg::WIN_BIT];
              next_s.wd_per  = b[1:0];
              next_s.wd_ms   = '0;
            end else begin
              // RQ16 unguarded byte dropped
              next_s.arm_mg = 1'b0;
              next_s.arm_wd = 1'b0;
            end
          end
        end
      end
      D_ACK: begin
        // Release data after the acknowledge clock pulse
        if (fall) begin
          next_s.sda_oe = 1'b0;
          next_s.st     = D_DATA;
        end
      end
    endcase

    // RQ9 STOP returns idle
    if (stop) begin
      next_s.st     = D_IDLE;
      next_s.sda_oe = 1'b0;
      next_s.arm_mg = 1'b0;
      next_s.arm_wd = 1'b0;
      next_s.last_wdg = 1'b0;
    end else if (start) begin
      // Guards never carry over from an earlier transfer
      next_s.st       = D_ADDR;
      next_s.bitcnt   = '0;
      next_s.sda_oe   = 1'b0;
      next_s.arm_mg   = 1'b0;
      next_s.arm_wd   = 1'b0;
      next_s.last_wdg = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Idle bus is high; regulator starts enabled; margins nominal
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s        <= '0;
      s.scl_q  <= 1'b1;
      s.sda_q  <= 1'b1;
      s.ldo_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.d_scl_out          = 1'b0;  // Never stretches the clock
  assign link.d_scl_oe           = 1'b0;
  assign link.d_sda_out          = 1'b0;  // Open drain: only pulls low
  assign link.d_sda_oe           = s.sda_oe;
  assign ldo_margin_code         = s.ldo_code;
  assign sw_margin_code          = s.sw_code;
  assign supervisor_timer_on     = s.wd_on;
  assign supervisor_timer_window = s.wd_win;
  assign supervisor_timer_period = s.wd_per;
  assign supervisor_timeout      = s.timeout;
  assign ldo_enable              = s.ldo_en;
  assign ldo_limit_active        = s.ilim_act;

endmodule
`default_nettype wire

//--- hdl/i2c_cmd_master.sv
// Controller end: APB slave registers driving a two-wire write master.
// Builds guarded frames in hardware so software cannot skip a guard.
// Assumes one core clock and a sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module i2c_cmd_master (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  i2c_link_if.master       link
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_STOP
  } mst_t;

  typedef struct packed {
    mst_t        st;        // Frame engine state
    logic [1:0]  ph;        // Quarter of the bit period
    logic [15:0] qcnt;      // Quarter period counter
    logic [3:0]  bitn;      // Bit within byte, 8 = acknowledge
    logic [1:0]  byte_i;    // Byte within frame
    logic [1:0]  last_i;    // Index of final byte
    logic [31:0] frame;     // Bytes to send, MSB first
    logic        nack;      // Last frame was refused
    logic        scl_oe;    // Pulling clock low
    logic        sda_oe;    // Pulling data low
    logic [1:0]  kind;      // Frame kind
    logic [1:0]  sel;       // Device address bits
    logic [12:0] data;      // Value fields
    logic [15:0] div;       // Quarter period in cycles
    logic [1:0]  int_st;    // Sticky events
    logic [1:0]  int_mask;  // Event enables
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mst_state_t;

  mst_state_t s;
  mst_state_t next_s;

  // Short local copies of field positions keep lines readable
  localparam int CTRL_GO_W       = i2c_margin_pkg::CTRL_GO;
  localparam int CTRL_KIND_LSB_W = i2c_margin_pkg::CTRL_KIND_LSB;
  localparam int CTRL_SEL_LSB_W  = i2c_margin_pkg::CTRL_SEL_LSB;
  localparam int DATA_V1_LSB_W   = i2c_margin_pkg::DATA_V1_LSB;
  localparam int INT_DONE_W      = i2c_margin_pkg::INT_DONE;
  localparam int INT_NACK_W      = i2c_margin_pkg::INT_NACK;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic       wr;
    logic       tick;
    logic [1:0] ev;
    wr   = psel && penable && s.pready && pwrite;
    tick = (s.qcnt == 16'd0);
    ev   = '0;
    next_s = s;

    // APB: answer prepared in setup, so access sees pready at once
    next_s.pready  = psel && !penable;
    next_s.pslverr = 1'b0;
    next_s.prdata  = '0;
    if (psel && !penable) begin
      unique case (paddr)
        i2c_margin_pkg::REG_CTRL:       next_s.prdata = 32'({s.sel, s.kind, 1'b0});
        i2c_margin_pkg::REG_DATA:       next_s.prdata = 32'(s.data);
        i2c_margin_pkg::REG_STATUS:     next_s.prdata = 32'({s.nack, s.st != M_IDLE});
        i2c_margin_pkg::REG_INT_STATUS: next_s.prdata = 32'(s.int_st);
        i2c_margin_pkg::REG_INT_MASK:   next_s.prdata = 32'(s.int_mask);
        i2c_margin_pkg::REG_DIV:        next_s.prdata = 32'(s.div);
        default:                        next_s.pslverr = 1'b1;
      endcase
    end

    // Quarter-period tick
    next_s.qcnt = tick ? s.div - 16'd1 : s.qcnt - 16'd1;
    if (s.st == M_IDLE) begin
      next_s.qcnt = '0;
    end

    // Frame engine
    unique case (s.st)
      M_IDLE: begin
        next_s.ph = '0;
      end
      M_START: if (tick) begin
        next_s.ph = s.ph + 2'd1;
        if (s.ph == 2'd0) begin
          next_s.sda_oe = 1'b1;   // Data falls with clock high
        end else begin
          next_s.scl_oe = 1'b1;
          next_s.st     = M_BIT;
          next_s.ph     = '0;
        end
      end
      M_BIT: if (tick) begin
        next_s.ph = s.ph + 2'd1;
        unique case (s.ph)
          2'd0: next_s.sda_oe = (s.bitn < 4'd8) ? !s.frame[31] : 1'b0;
          2'd1: next_s.scl_oe = 1'b0;
          2'd2: if (s.bitn == 4'd8) next_s.nack = link.sda;
          2'd3: begin
            next_s.scl_oe = 1'b1;
            if (s.bitn < 4'd8) begin
              next_s.frame = {s.frame[30:0], 1'b0};
              next_s.bitn  = s.bitn + 4'd1;
            end else if (s.nack || s.byte_i == s.last_i) begin
              // RQ9 end with STOP
              next_s.st = M_STOP;
            end else begin
              next_s.bitn   = '0;
              next_s.byte_i = s.byte_i + 2'd1;
            end
          end
        endcase
      end
      M_STOP: if (tick) begin
        next_s.ph = s.ph + 2'd1;
        unique case (s.ph)
          2'd0: next_s.sda_oe = 1'b1;
          2'd1: next_s.scl_oe = 1'b0;
          2'd2: next_s.sda_oe = 1'b0;  // Data rises with clock high
          2'd3: begin
            next_s.st = M_IDLE;
            ev[INT_DONE_W] = 1'b1;
            ev[INT_NACK_W] = s.nack;
          end
        endcase
      end
    endcase

    // Register writes take effect in the access cycle
    if (wr) begin
      unique case (paddr)
        i2c_margin_pkg::REG_CTRL: if (s.st == M_IDLE) begin
          next_s.kind = pwdata[CTRL_KIND_LSB_W +: 2];
          next_s.sel  = pwdata[CTRL_SEL_LSB_W +: 2];
        end
        i2c_margin_pkg::REG_DATA:     next_s.data     = pwdata[12:0];
        i2c_margin_pkg::REG_INT_MASK: next_s.int_mask = pwdata[1:0];
        i2c_margin_pkg::REG_DIV:      next_s.div      = (pwdata[15:0] == 16'd0) ? 16'd1 : pwdata[15:0];
        default: ;
      endcase
      // Start only when idle; a go while busy is dropped
      if (paddr == i2c_margin_pkg::REG_CTRL && pwdata[CTRL_GO_W] && s.st == M_IDLE) begin
        next_s.st     = M_START;
        next_s.nack   = 1'b0;
        next_s.bitn   = '0;
        next_s.byte_i = '0;
        // RQ10 write direction always
        next_s.frame[31:24] = {i2c_margin_pkg::ADDR_FIXED, pwdata[CTRL_SEL_LSB_W +: 2], 1'b0};
        // RQ1 guard byte before payload
        next_s.frame[23:16] = (pwdata[CTRL_KIND_LSB_W +: 2] >= 2'(i2c_margin_pkg::KIND_WD_SERVICE)) ?
                              i2c_margin_pkg::GUARD_WD : i2c_margin_pkg::GUARD_MARGIN;
        next_s.frame[15:0]  = '0;
        next_s.last_i       = 2'd2;
        unique case (i2c_margin_pkg::kind_t'(pwdata[CTRL_KIND_LSB_W +: 2]))
          i2c_margin_pkg::KIND_MARGIN_ONE:  next_s.frame[15:8] = {i2c_margin_pkg::OP_MARGIN, s.data[4:0]};
          // RQ3 two supply bytes
          i2c_margin_pkg::KIND_MARGIN_BOTH: begin
            next_s.frame[15:0] = {i2c_margin_pkg::OP_MARGIN, s.data[4:0],
                                  i2c_margin_pkg::OP_MARGIN, s.data[DATA_V1_LSB_W + 4 -: 5]};
            next_s.last_i      = 2'd3;
          end
          // RQ4 guard then period
          i2c_margin_pkg::KIND_WD_SERVICE:  next_s.frame[15:8] = {i2c_margin_pkg::OP_WATCHDOG, s.data[4:0]};
          i2c_margin_pkg::KIND_WD_OFF:      next_s.frame[15:8] = i2c_margin_pkg::GUARD_WD;
        endcase
      end
    end

    // Sticky events: a new event wins over a same-cycle clear
    next_s.int_st = s.int_st;
    if (wr && paddr == i2c_margin_pkg::REG_INT_STATUS) begin
      next_s.int_st = s.int_st & ~pwdata[1:0];
    end
    next_s.int_st = next_s.int_st | ev;
    next_s.irq    = |(next_s.int_st & next_s.int_mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s     <= '0;
      s.div <= i2c_margin_pkg::DIV_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign link.m_scl_out = 1'b0;
  assign link.m_scl_oe  = s.scl_oe;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe  = s.sda_oe;
  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign irq            = s.irq;

endmodule
`default_nettype wire

//--- verif/i2c_margin_watchdog_cmd_sva.sv
// Checks on the device end of the two-wire command link.
// Assumes one core clock and a sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
module i2c_margin_watchdog_cmd_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       scl,
  input wire logic       d_sda_oe,
  input wire logic       ldo_overcurrent,
  input wire logic       ldo_enable,
  input wire logic       ldo_limit_active,
  input wire logic [3:0] ldo_margin_code,
  input wire logic [3:0] sw_margin_code,
  input wire logic       supervisor_timer_on,
  input wire logic [1:0] supervisor_timer_period,
  input wire logic       supervisor_timeout
);
  // One clock domain, so one clocking and one disable
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_lim_on; ldo_enable && ldo_overcurrent |=> ldo_limit_active; endproperty
  a_lim_on: assert property (p_lim_on) else $error("limit flag missed");
  property p_lim_off; !ldo_overcurrent |=> !ldo_limit_active; endproperty
  a_lim_off: assert property (p_lim_off) else $error("limit flag without cause");
  property p_trip; $fell(ldo_enable) |-> $past(ldo_overcurrent); endproperty
  a_trip: assert property (p_trip) else $error("regulator off without overcurrent");
  property p_retry; $fell(ldo_enable) |=> !ldo_enable [*8]; endproperty
  a_retry: assert property (p_retry) else $error("retry came too soon");
  property p_ack; $rose(d_sda_oe) |-> !scl; endproperty
  a_ack: assert property (p_ack) else $error("ack pull while clock high");
  property p_pulse; supervisor_timeout |=> !supervisor_timeout; endproperty
  a_pulse: assert property (p_pulse) else $error("timeout longer than a cycle");
  property p_per; $changed(supervisor_timer_period) |-> supervisor_timer_on; endproperty
  a_per: assert property (p_per) else $error("period set but timer off");
  property p_off; $fell(supervisor_timer_on) |-> $stable(supervisor_timer_period); endproperty
  a_off: assert property (p_off) else $error("disable altered period");
  // A byte names one supply, so both codes never move together
  property p_one; $changed(ldo_margin_code) |-> $stable(sw_margin_code); endproperty
  a_one: assert property (p_one) else $error("both margins moved at once");
endmodule
`default_nettype wire

//--- verif/i2c_margin_watchdog_cmd_test.sv
// Bench joining controller and device; APB calls drive the frames.
// Assumes the package and link interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module i2c_margin_watchdog_cmd_test;
  logic        core_clk, rst, psel, penable, pwrite, irq, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        oscillator_mode_strap, addr_strap, ldo_overcurrent, ldo_enable, ldo_limit_active;
  logic [3:0]  ldo_margin_code, sw_margin_code;
  logic [1:0]  supervisor_timer_period;
  logic        supervisor_timer_on, supervisor_timer_window, supervisor_timeout;
  int          num_errors, num_checks, cycles, timeouts;
  i2c_link_if link ();
  i2c_cmd_master u_i2c_cmd_master (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .link);
  // Short ms tick keeps the limit and supervisor times small
  i2c_margin_watchdog_cmd #(.MS_CYCLES(10)) u_i2c_margin_watchdog_cmd (.core_clk, .rst, .link,
    .oscillator_mode_strap, .addr_strap, .ldo_overcurrent, .ldo_margin_code, .sw_margin_code,
    .supervisor_timer_on, .supervisor_timer_window, .supervisor_timer_period, .supervisor_timeout,
    .ldo_enable, .ldo_limit_active);
  i2c_margin_watchdog_cmd_sva u_i2c_margin_watchdog_cmd_sva (.core_clk, .rst, .scl(link.scl),
    .d_sda_oe(link.d_sda_oe), .ldo_overcurrent, .ldo_enable, .ldo_limit_active, .ldo_margin_code,
    .sw_margin_code, .supervisor_timer_on, .supervisor_timer_period, .supervisor_timeout);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; entered just after a rising edge, idles one cycle after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    if (!w) rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Send one frame, poll for its end, then clear both events
  task automatic frame(input logic [1:0] k, input logic [1:0] sel, input logic [12:0] d);
    apb(1'b1, 8'h04, {19'h0, d});
    apb(1'b1, 8'h00, {27'h0, sel, k, 1'b1});
    do apb(1'b0, 8'h0C, 32'h0); while (rd[1:0] == 2'h0);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 8'h0C, 32'h3);
    check("irq clr", {31'h0, irq}, 32'h0);
  endtask
  // Cut a hang short
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (supervisor_timeout) timeouts <= timeouts + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    {psel, penable, pwrite, ldo_overcurrent, addr_strap} = 5'h0;
    paddr = 8'h00; pwdata = 32'h0; oscillator_mode_strap = 1'b1; rst = 1'b1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b1, 8'h14, 32'h4);
    apb(1'b1, 8'h10, 32'h1);
    frame(2'h1, 2'h2, 13'h1C05);
    check("margin", {24'h0, ldo_margin_code, sw_margin_code}, 32'h5C);
    frame(2'h0, 2'h1, 13'h0001);
    check("nack", {31'h0, rd[1]}, 32'h1);
    check("margin", {24'h0, ldo_margin_code, sw_margin_code}, 32'h5C);
    frame(2'h2, 2'h2, 13'h000B);
    check("wd", {28'h0, supervisor_timer_on, supervisor_timer_window, supervisor_timer_period}, 32'hB);
    frame(2'h2, 2'h2, 13'h000D);
    check("wd", {28'h0, supervisor_timer_on, supervisor_timer_window, supervisor_timer_period}, 32'hD);
    frame(2'h3, 2'h2, 13'h0000);
    check("wd on", {31'h0, supervisor_timer_on}, 32'h0);
    frame(2'h2, 2'h2, 13'h000A);
    check("wd", {28'h0, supervisor_timer_on, supervisor_timer_window, supervisor_timer_period}, 32'hA);
    ldo_overcurrent <= 1'b1;
    repeat (5) @(posedge core_clk);
    check("limit", {30'h0, ldo_enable, ldo_limit_active}, 32'h3);
    repeat (115) @(posedge core_clk);
    ldo_overcurrent <= 1'b0;
    check("ldo off", {31'h0, ldo_enable}, 32'h0);
    repeat (1100) @(posedge core_clk);
    check("ldo back", {31'h0, ldo_enable}, 32'h1);
    check("timeouts", {31'h0, timeouts != 0}, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
